/* alit_pkg.sv */
// Shared constants and types for the arithmetic and logic execution unit
package alit_pkg;
	localparam int MC_BASE_CLKS = 4;
	localparam int WAIT_W = 3;
	localparam int DIV_W = 3;
	localparam int CLK_W = 12;
	localparam int MC_W = 3;
	localparam int LEN_W = 2;
	localparam int RUN_W = 15;
	localparam logic [LEN_W-1:0] LEN_ONE = 2'h1;
	localparam logic [LEN_W-1:0] LEN_TWO = 2'h2;
	localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;
	localparam logic [MC_W-1:0] MC_ONE = 3'h1;
	localparam logic [MC_W-1:0] MC_TWO = 3'h2;
	localparam logic [MC_W-1:0] MC_FOUR = 3'h4;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;

	typedef enum logic [4:0] {
		OP_ADD, OP_ADD_CY, OP_SUB_BW, OP_PLUS1, OP_MINUS1, OP_DP_PLUS1,
		OP_PRODUCT, OP_QUOTIENT, OP_BCD_FIX, OP_AND, OP_OR, OP_XOR,
		OP_NIB_SWAP, OP_ZERO, OP_INVERT, OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC
	} alit_op_t;

	// Operand form: source of the second operand and where the result goes
	typedef enum logic [2:0] {
		FM_MAIN, FM_REG, FM_DIRECT, FM_INDIRECT, FM_IMM, FM_DIR_MAIN, FM_DIR_IMM
	} alit_form_t;

	typedef struct packed {
		alit_op_t op;
		alit_form_t form;
		logic [7:0] main_operand;
		logic [7:0] src;
		logic [7:0] imm;
		logic [7:0] b_val;
		logic [15:0] data_pointer;
		logic carry;
		logic aux;
	} alit_req_t;

	typedef struct packed {
		logic [7:0] main_operand;
		logic [7:0] b_val;
		logic [15:0] data_pointer;
		logic [7:0] mem_data;
		logic carry;
		logic aux;
		logic ovf;
		logic wr_main;
		logic wr_mem;
		logic wr_b;
		logic wr_dp;
	} alit_res_t;

	localparam alit_res_t RES_RST = '{BYTE_RST, BYTE_RST, WORD_RST, BYTE_RST,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

/* alit_exec.sv */
// Arithmetic and logic execution unit with machine-cycle accounting
`timescale 1ns/1ps

// Overview of operation
// - Machine cycle length comes from wait-state and clock divider settings, base four clocks.
// - A prefetch queue stall holds the current machine cycle longer.
// - A taken branch missing the branch cache holds the machine cycle longer.
// - Without stalls or misses every instruction takes exactly its listed cycle count.
// - Add into main operand: one cycle; one byte register/indirect, two direct/immediate.
// - Add with carry: source plus carry into main operand, same lengths as add.
// - Subtract with borrow: one cycle, one or two bytes by operand form.
// - AND into main operand or direct byte, one cycle; immediate-to-direct three bytes, two cycles.
// - OR likewise; immediate-to-direct form is three bytes and two cycles.
// - XOR likewise; immediate-to-direct form is three bytes and two cycles.
// - Nibble swap of main operand, one byte, one cycle.
// - Rotate left plain or through carry, one byte, one cycle.
// - Rotate right plain or through carry, one byte, one cycle.
module alit_exec
	import alit_pkg::*;
#(
	parameter int BASE_CLKS = MC_BASE_CLKS
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire alit_req_t req_in,
	input wire logic [WAIT_W-1:0] bus_wait_config,
	input wire logic [DIV_W-1:0] cpu_clock_divider_ctl,
	input wire logic prefetch_queue_stall,
	input wire logic branch_target_cache_miss,
	output logic ready,
	output logic busy,
	output logic done,
	output alit_res_t result,
	output logic [LEN_W-1:0] instr_len,
	output logic [MC_W-1:0] instr_cycles
);
	typedef enum logic {ST_IDLE, ST_EXEC} alit_state_t;

	function automatic logic is_two_byte(alit_form_t f);
		return f == FM_DIRECT || f == FM_IMM || f == FM_DIR_MAIN;
	endfunction

	function automatic logic [LEN_W-1:0] len_of(alit_op_t op, alit_form_t f);
		logic [LEN_W-1:0] l;
		l = LEN_ONE;
		if ((op == OP_AND || op == OP_OR || op == OP_XOR) && f == FM_DIR_IMM) begin
			l = LEN_THREE;
		end else if (op == OP_ADD || op == OP_ADD_CY || op == OP_SUB_BW || op == OP_AND || op == OP_OR ||
			op == OP_XOR || op == OP_PLUS1 || op == OP_MINUS1) begin
			l = is_two_byte(f) ? LEN_TWO : LEN_ONE;
		end
		return l;
	endfunction

	function automatic logic [MC_W-1:0] cycles_of(alit_op_t op, alit_form_t f);
		logic [MC_W-1:0] c;
		c = MC_ONE;
		if ((op == OP_AND || op == OP_OR || op == OP_XOR) && f == FM_DIR_IMM) begin
			c = MC_TWO;
		end else if (op == OP_DP_PLUS1) begin
			c = MC_TWO;
		end else if (op == OP_PRODUCT || op == OP_QUOTIENT) begin
			c = MC_FOUR;
		end
		return c;
	endfunction

	// Native machine cycle: base clocks plus wait states, scaled by the divider
	function automatic logic [CLK_W-1:0] native_of(logic [WAIT_W-1:0] w, logic [DIV_W-1:0] d);
		logic [CLK_W-1:0] n;
		n = CLK_W'(BASE_CLKS) + CLK_W'(w);
		return n << d;
	endfunction

	function automatic alit_res_t exec_op(alit_req_t r);
		alit_res_t o;
		logic [8:0] w9;
		logic [4:0] h5;
		logic [7:0] opnd;
		logic [7:0] lres;
		logic [15:0] prod;
		o = RES_RST;
		o.main_operand = r.main_operand;
		o.b_val = r.b_val;
		o.data_pointer = r.data_pointer;
		o.carry = r.carry;
		o.aux = r.aux;
		w9 = 9'h000;
		h5 = 5'h00;
		prod = 16'h0000;
		opnd = (r.form == FM_DIR_IMM) ? r.imm : r.main_operand;
		lres = 8'h00;
		case (r.op)
			OP_ADD, OP_ADD_CY: begin
				w9 = {1'b0, r.main_operand} + {1'b0, r.src} + {8'h00, r.op == OP_ADD_CY && r.carry};
				h5 = {1'b0, r.main_operand[3:0]} + {1'b0, r.src[3:0]} + {4'h0, r.op == OP_ADD_CY && r.carry};
				o.main_operand = w9[7:0];
				o.carry = w9[8];
				o.aux = h5[4];
				o.ovf = (r.main_operand[7] == r.src[7]) && (w9[7] != r.main_operand[7]);
				o.wr_main = 1'b1;
			end
			OP_SUB_BW: begin
				w9 = {1'b0, r.main_operand} - {1'b0, r.src} - {8'h00, r.carry};
				h5 = {1'b0, r.main_operand[3:0]} - {1'b0, r.src[3:0]} - {4'h0, r.carry};
				o.main_operand = w9[7:0];
				o.carry = w9[8];
				o.aux = h5[4];
				o.ovf = (r.main_operand[7] != r.src[7]) && (w9[7] != r.main_operand[7]);
				o.wr_main = 1'b1;
			end
			OP_PLUS1, OP_MINUS1: begin
				lres = (r.form == FM_MAIN) ? r.main_operand : r.src;
				lres = (r.op == OP_PLUS1) ? lres + 8'h01 : lres - 8'h01;
				o.wr_main = r.form == FM_MAIN;
				o.wr_mem = r.form != FM_MAIN;
				o.main_operand = (r.form == FM_MAIN) ? lres : r.main_operand;
				o.mem_data = lres;
			end
			OP_DP_PLUS1: begin
				o.data_pointer = r.data_pointer + 16'h0001;
				o.wr_dp = 1'b1;
			end
			OP_PRODUCT: begin
				prod = {8'h00, r.main_operand} * {8'h00, r.b_val};
				o.main_operand = prod[7:0];
				o.b_val = prod[15:8];
				o.carry = 1'b0;
				o.ovf = prod[15:8] != 8'h00;
				o.wr_main = 1'b1;
				o.wr_b = 1'b1;
			end
			OP_QUOTIENT: begin
				// Zero divisor flags overflow and leaves both bytes all ones
				o.carry = 1'b0;
				o.ovf = r.b_val == 8'h00;
				o.main_operand = (r.b_val == 8'h00) ? 8'hFF : r.main_operand / r.b_val;
				o.b_val = (r.b_val == 8'h00) ? 8'hFF : r.main_operand % r.b_val;
				o.wr_main = 1'b1;
				o.wr_b = 1'b1;
			end
			OP_BCD_FIX: begin
				w9 = {1'b0, r.main_operand};
				if (w9[3:0] > 4'h9 || r.aux) begin
					w9 = w9 + 9'h006;
				end
				if (w9[8] || r.carry || w9[7:4] > 4'h9) begin
					w9 = {1'b1, w9[7:0] + 8'h60};
				end
				o.main_operand = w9[7:0];
				o.carry = w9[8];
				o.wr_main = 1'b1;
			end
			OP_AND, OP_OR, OP_XOR: begin
				lres = (r.op == OP_AND) ? (r.src & opnd) : (r.op == OP_OR) ? (r.src | opnd) : (r.src ^ opnd);
				o.wr_mem = r.form == FM_DIR_MAIN || r.form == FM_DIR_IMM;
				o.wr_main = !o.wr_mem;
				o.mem_data = lres;
				o.main_operand = o.wr_mem ? r.main_operand : lres;
			end
			OP_NIB_SWAP: begin
				o.main_operand = {r.main_operand[3:0], r.main_operand[7:4]};
				o.wr_main = 1'b1;
			end
			OP_ZERO: begin
				o.main_operand = 8'h00;
				o.wr_main = 1'b1;
			end
			OP_INVERT: begin
				o.main_operand = ~r.main_operand;
				o.wr_main = 1'b1;
			end
			OP_ROT_L: begin
				o.main_operand = {r.main_operand[6:0], r.main_operand[7]};
				o.wr_main = 1'b1;
			end
			OP_ROT_LC: begin
				o.main_operand = {r.main_operand[6:0], r.carry};
				o.carry = r.main_operand[7];
				o.wr_main = 1'b1;
			end
			OP_ROT_R: begin
				o.main_operand = {r.main_operand[0], r.main_operand[7:1]};
				o.wr_main = 1'b1;
			end
			OP_ROT_RC: begin
				o.main_operand = {r.carry, r.main_operand[7:1]};
				o.carry = r.main_operand[0];
				o.wr_main = 1'b1;
			end
			default: begin
				o.wr_main = 1'b0;
			end
		endcase
		return o;
	endfunction

	alit_state_t state_reg, state_next;
	alit_req_t req_reg, req_next;
	alit_res_t res_reg, res_next;
	logic done_reg, done_next;
	logic [LEN_W-1:0] len_reg, len_next;
	logic [MC_W-1:0] cycles_reg, cycles_next;
	logic [MC_W-1:0] mc_cnt_reg, mc_cnt_next;
	logic [CLK_W-1:0] native_reg, native_next;
	logic [CLK_W-1:0] clk_cnt_reg, clk_cnt_next;
	logic stretch;
	logic take;

	assign ready = state_reg == ST_IDLE;
	assign busy = state_reg == ST_EXEC;
	assign done = done_reg;
	assign result = res_reg;
	assign instr_len = len_reg;
	assign instr_cycles = cycles_reg;
	assign take = start && state_reg == ST_IDLE;
	assign stretch = prefetch_queue_stall || branch_target_cache_miss;

	always_comb begin
		state_next = state_reg;
		req_next = req_reg;
		res_next = res_reg;
		done_next = 1'b0;
		len_next = len_reg;
		cycles_next = cycles_reg;
		mc_cnt_next = mc_cnt_reg;
		native_next = native_reg;
		clk_cnt_next = clk_cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					state_next = ST_EXEC;
					req_next = req_in;
					len_next = len_of(req_in.op, req_in.form);
					cycles_next = cycles_of(req_in.op, req_in.form);
					native_next = native_of(bus_wait_config, cpu_clock_divider_ctl);
					mc_cnt_next = '0;
					clk_cnt_next = '0;
				end
			end
			ST_EXEC: begin
				// A stretched clock does not count toward the machine cycle
				if (!stretch) begin
					if (clk_cnt_reg == native_reg - CLK_W'(1)) begin
						clk_cnt_next = '0;
						if (mc_cnt_reg == cycles_reg - MC_W'(1)) begin
							state_next = ST_IDLE;
							res_next = exec_op(req_reg);
							done_next = 1'b1;
						end else begin
							mc_cnt_next = mc_cnt_reg + MC_W'(1);
						end
					end else begin
						clk_cnt_next = clk_cnt_reg + CLK_W'(1);
					end
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			req_reg <= '0;
			res_reg <= RES_RST;
			done_reg <= 1'b0;
			len_reg <= LEN_ONE;
			cycles_reg <= MC_ONE;
			mc_cnt_reg <= '0;
			native_reg <= CLK_W'(MC_BASE_CLKS);
			clk_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			req_reg <= req_next;
			res_reg <= res_next;
			done_reg <= done_next;
			len_reg <= len_next;
			cycles_reg <= cycles_next;
			mc_cnt_reg <= mc_cnt_next;
			native_reg <= native_next;
			clk_cnt_reg <= clk_cnt_next;
		end
	end

	// Helper: unstretched clocks spent in the current instruction
	logic [RUN_W-1:0] run_cnt_reg, run_cnt_next;
	always_comb begin
		run_cnt_next = run_cnt_reg;
		if (take) begin
			run_cnt_next = '0;
		end else if (busy && !stretch) begin
			run_cnt_next = run_cnt_reg + RUN_W'(1);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_cnt_reg <= '0;
		end else begin
			run_cnt_reg <= run_cnt_next;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_take(alit_op_t o);
		take && req_in.op == o;
	endsequence
	sequence s_finish(alit_op_t o);
		done_reg && req_reg.op == o;
	endsequence

	property p_native_len;
		done_reg |-> run_cnt_reg == RUN_W'(cycles_reg) * RUN_W'(native_reg);
	endproperty
	a_native_len: assert property (p_native_len) else $error("instruction length not cycles times native");

	property p_native_set;
		take |=> native_reg == ((CLK_W'(BASE_CLKS) + CLK_W'($past(bus_wait_config))) << $past(cpu_clock_divider_ctl));
	endproperty
	a_native_set: assert property (p_native_set) else $error("native cycle length wrong");

	property p_pfq_stall;
		busy && prefetch_queue_stall |=> $stable(clk_cnt_reg) && $stable(mc_cnt_reg) && !done_reg;
	endproperty
	a_pfq_stall: assert property (p_pfq_stall) else $error("prefetch stall did not hold cycle");

	property p_cache_miss;
		busy && branch_target_cache_miss |=> $stable(clk_cnt_reg) && busy;
	endproperty
	a_cache_miss: assert property (p_cache_miss) else $error("cache miss did not hold cycle");

	property p_add;
		s_finish(OP_ADD) |-> result.main_operand == req_reg.main_operand + req_reg.src;
	endproperty
	a_add: assert property (p_add) else $error("add result wrong");

	property p_add_cy;
		s_finish(OP_ADD_CY) |-> {result.carry, result.main_operand} ==
			{1'b0, req_reg.main_operand} + {1'b0, req_reg.src} + {8'h00, req_reg.carry};
	endproperty
	a_add_cy: assert property (p_add_cy) else $error("add with carry wrong");

	property p_sub_bw;
		s_finish(OP_SUB_BW) |-> result.main_operand == req_reg.main_operand - req_reg.src - {7'h00, req_reg.carry};
	endproperty
	a_sub_bw: assert property (p_sub_bw) else $error("subtract with borrow wrong");

	property p_and_dir_imm;
		s_take(OP_AND) ##0 req_in.form == FM_DIR_IMM |=> len_reg == LEN_THREE && cycles_reg == MC_TWO;
	endproperty
	a_and_dir_imm: assert property (p_and_dir_imm) else $error("and immediate to direct timing");

	property p_or_dir_imm;
		s_take(OP_OR) ##0 req_in.form == FM_DIR_IMM |=> len_reg == LEN_THREE && cycles_reg == MC_TWO;
	endproperty
	a_or_dir_imm: assert property (p_or_dir_imm) else $error("or immediate to direct timing");

	property p_xor_dir_imm;
		s_take(OP_XOR) ##0 req_in.form == FM_DIR_IMM |=> len_reg == LEN_THREE && cycles_reg == MC_TWO;
	endproperty
	a_xor_dir_imm: assert property (p_xor_dir_imm) else $error("xor immediate to direct timing");

	property p_swap;
		s_finish(OP_NIB_SWAP) |-> result.main_operand == {req_reg.main_operand[3:0], req_reg.main_operand[7:4]};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");

	property p_rot_lc;
		s_finish(OP_ROT_LC) |-> {result.carry, result.main_operand} == {req_reg.main_operand, req_reg.carry};
	endproperty
	a_rot_lc: assert property (p_rot_lc) else $error("rotate left through carry wrong");

	property p_rot_r;
		s_finish(OP_ROT_R) |-> result.main_operand == {req_reg.main_operand[0], req_reg.main_operand[7:1]};
	endproperty
	a_rot_r: assert property (p_rot_r) else $error("rotate right wrong");

	property p_dp_plus1;
		s_take(OP_DP_PLUS1) |=> cycles_reg == MC_TWO && len_reg == LEN_ONE;
	endproperty
	a_dp_plus1: assert property (p_dp_plus1) else $error("data pointer increment timing");

	property p_product;
		s_take(OP_PRODUCT) |=> cycles_reg == MC_FOUR && len_reg == LEN_ONE;
	endproperty
	a_product: assert property (p_product) else $error("multiply timing wrong");

	property p_zero;
		s_finish(OP_ZERO) |-> result.main_operand == 8'h00 && instr_cycles == MC_ONE;
	endproperty
	a_zero: assert property (p_zero) else $error("clear result wrong");
endmodule

/* alit_fetch_model.sv */
// Fetch unit and branch cache stand-in driving stall and miss levels
`timescale 1ns/1ps
module alit_fetch_model
	import alit_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [1:0] stall_mode,
	output logic prefetch_queue_stall,
	output logic branch_target_cache_miss
);
	logic [7:0] lfsr_reg;
	logic [7:0] lfsr_next;

	always_comb begin
		lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lfsr_reg <= 8'hA5;
			prefetch_queue_stall <= 1'b0;
			branch_target_cache_miss <= 1'b0;
		end else begin
			lfsr_reg <= lfsr_next;
			// Queue refill stalls in bursts
			prefetch_queue_stall <= stall_mode[0] & lfsr_reg[1] & lfsr_reg[6];
			// Taken branch that misses the cache
			branch_target_cache_miss <= stall_mode[1] & (lfsr_reg[2:0] == 3'h0);
		end
	end
endmodule

/* arith_logic_instr_timing_test.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module arith_logic_instr_timing_test;
	import alit_pkg::*;
	logic ref_clk, rst_n, start, ready, busy, done, pq_stall, miss_lvl;
	alit_req_t req_in;
	alit_res_t result;
	logic [WAIT_W-1:0] bus_wait_config;
	logic [DIV_W-1:0] cpu_clock_divider_ctl;
	logic [1:0] stall_mode;
	logic [LEN_W-1:0] instr_len;
	logic [MC_W-1:0] instr_cycles;
	logic [31:0] seed;
	int miscompares, n_compared;

	alit_exec i_alit_exec (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .req_in(req_in),
		.bus_wait_config(bus_wait_config), .cpu_clock_divider_ctl(cpu_clock_divider_ctl),
		.prefetch_queue_stall(pq_stall), .branch_target_cache_miss(miss_lvl), .ready(ready),
		.busy(busy), .done(done), .result(result), .instr_len(instr_len), .instr_cycles(instr_cycles));
	alit_fetch_model i_alit_fetch_model (.ref_clk(ref_clk), .rst_n(rst_n), .stall_mode(stall_mode),
		.prefetch_queue_stall(pq_stall), .branch_target_cache_miss(miss_lvl));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic bit legal(input alit_op_t o, input alit_form_t f);
		case (o)
			OP_ADD, OP_ADD_CY, OP_SUB_BW: return f inside {FM_REG, FM_DIRECT, FM_INDIRECT, FM_IMM};
			OP_PLUS1, OP_MINUS1: return f inside {FM_MAIN, FM_REG, FM_DIRECT, FM_INDIRECT};
			OP_AND, OP_OR, OP_XOR: return f != FM_MAIN;
			default: return f == FM_MAIN;
		endcase
	endfunction

	function automatic alit_req_t rnd_req();
		alit_req_t q;
		logic [63:0] v;
		v = {nxt(), nxt()};
		q = v[$bits(alit_req_t)-1:0];
		q.op = alit_op_t'(5'(nxt() % 19));
		q.form = alit_form_t'(3'(nxt() % 7));
		while (!legal(q.op, q.form)) q.form = alit_form_t'(3'(nxt() % 7));
		return q;
	endfunction

	function automatic logic [LEN_W-1:0] elen(input alit_req_t q);
		if (q.form == FM_DIR_IMM) return LEN_THREE;
		return (q.form inside {FM_DIRECT, FM_IMM, FM_DIR_MAIN}) ? LEN_TWO : LEN_ONE;
	endfunction

	function automatic logic [MC_W-1:0] ecyc(input alit_req_t q);
		if (q.op inside {OP_PRODUCT, OP_QUOTIENT}) return MC_FOUR;
		return (q.op == OP_DP_PLUS1 || q.form == FM_DIR_IMM) ? MC_TWO : MC_ONE;
	endfunction

	function automatic alit_res_t exp_res(input alit_req_t q);
		alit_res_t e;
		logic [8:0] w;
		logic [15:0] p;
		logic [7:0] a, s, x, y;
		logic ci;
		a = q.main_operand;
		s = q.src;
		ci = (q.op == OP_ADD) ? 1'b0 : q.carry;
		e = RES_RST;
		e.carry = q.carry;
		e.aux = q.aux;
		e.wr_main = 1'b1;
		x = a;
		y = (q.form == FM_DIR_IMM) ? q.imm : a;
		p = {8'h00, a} * {8'h00, q.b_val};
		case (q.op)
			OP_ADD, OP_ADD_CY: begin
				w = {1'b0, a} + {1'b0, s} + {8'h00, ci};
				{e.carry, x} = w;
				e.aux = ({1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, ci}) > 5'h0F;
				e.ovf = (a[7] == s[7]) && (x[7] != a[7]);
			end
			OP_SUB_BW: begin
				w = {1'b0, a} - {1'b0, s} - {8'h00, ci};
				{e.carry, x} = w;
				e.aux = {1'b0, a[3:0]} < ({1'b0, s[3:0]} + {4'h0, ci});
				e.ovf = (a[7] != s[7]) && (x[7] != a[7]);
			end
			OP_PLUS1, OP_MINUS1: begin
				y = (q.op == OP_PLUS1) ? 8'h01 : 8'hFF;
				x = a + y;
				e.mem_data = s + y;
				e.wr_mem = q.form != FM_MAIN;
				e.wr_main = q.form == FM_MAIN;
			end
			OP_DP_PLUS1: {e.wr_main, e.wr_dp, e.data_pointer} = {2'b01, q.data_pointer + 16'h0001};
			OP_PRODUCT: {e.wr_b, e.carry, e.ovf, e.b_val, x} = {2'b10, |p[15:8], p};
			OP_QUOTIENT: begin
				x = (q.b_val == 8'h00) ? 8'hFF : a / q.b_val;
				e.b_val = (q.b_val == 8'h00) ? 8'hFF : a % q.b_val;
				{e.wr_b, e.carry, e.ovf} = {2'b10, q.b_val == 8'h00};
			end
			OP_BCD_FIX: begin
				w = {1'b0, a};
				if (a[3:0] > 4'h9 || q.aux) w = w + 9'h006;
				e.carry = q.carry | w[8];
				if (w[7:4] > 4'h9 || e.carry) w = {1'b0, w[7:0]} + 9'h060;
				e.carry = e.carry | w[8];
				x = w[7:0];
			end
			OP_AND, OP_OR, OP_XOR: begin
				x = (q.op == OP_AND) ? (s & y) : (q.op == OP_OR) ? (s | y) : (s ^ y);
				e.mem_data = x;
				e.wr_mem = q.form inside {FM_DIR_MAIN, FM_DIR_IMM};
				e.wr_main = !e.wr_mem;
			end
			OP_NIB_SWAP: x = {a[3:0], a[7:4]};
			OP_ZERO: x = 8'h00;
			OP_INVERT: x = ~a;
			OP_ROT_L: x = {a[6:0], a[7]};
			OP_ROT_R: x = {a[0], a[7:1]};
			OP_ROT_LC: {e.carry, x} = {a, q.carry};
			default: {x, e.carry} = {q.carry, a};
		endcase
		e.main_operand = x;
		return e;
	endfunction

	// Chained call: start already held through the previous done cycle
	task automatic run_op(input alit_req_t q, input logic [2:0] w, input logic [2:0] d, input bit hold,
		input bit chained);
		alit_res_t e, m;
		int nb, ns, k;
		e = exp_res(q);
		nb = 0;
		ns = 0;
		if (!chained) begin
			@(posedge ref_clk);
			start <= 1'b1;
			req_in <= q;
			bus_wait_config <= w;
			cpu_clock_divider_ctl <= d;
		end
		@(posedge ref_clk);
		if (!hold) start <= 1'b0;
		@(negedge ref_clk);
		chk({ready, busy, instr_len, instr_cycles}, {2'b01, elen(q), ecyc(q)});
		for (k = 0; k < 8000 && done !== 1'b1; k++) begin
			nb += int'(busy === 1'b1);
			ns += int'(busy === 1'b1 && (pq_stall || miss_lvl));
			@(negedge ref_clk);
		end
		if (k == 8000) begin
			miscompares++;
			finish_test();
		end
		chk({done, busy, ready}, 3'b101);
		chk(nb, int'(ecyc(q)) * ((MC_BASE_CLKS + int'(w)) << d) + ns);
		m = result;
		if (!e.wr_main) m.main_operand = e.main_operand;
		if (!e.wr_mem) m.mem_data = e.mem_data;
		if (!e.wr_b) m.b_val = e.b_val;
		if (!e.wr_dp) m.data_pointer = e.data_pointer;
		chk(m, e);
	endtask

	initial begin
		alit_req_t q;
		seed = 32'h0000004A;
		miscompares = 0;
		n_compared = 0;
		rst_n = 1'b0;
		start = 1'b0;
		req_in = '0;
		bus_wait_config = 3'h0;
		cpu_clock_divider_ctl = 3'h0;
		stall_mode = 2'h0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk({ready, busy, done, instr_len, instr_cycles, result}, {3'b100, LEN_ONE, MC_ONE, RES_RST});
		for (int o = 0; o < 19; o++) begin
			for (int f = 0; f < 7; f++) begin
				q = rnd_req();
				q.op = alit_op_t'(o);
				q.form = alit_form_t'(f);
				if (legal(q.op, q.form)) run_op(q, 3'h0, 3'h0, 1'b0, 1'b0);
			end
		end
		q.op = OP_QUOTIENT;
		q.form = FM_MAIN;
		q.b_val = 8'h00;
		run_op(q, 3'h2, 3'h1, 1'b1, 1'b0);
		run_op(q, 3'h2, 3'h1, 1'b0, 1'b1);
		q.op = OP_PRODUCT;
		q.main_operand = 8'hFF;
		q.b_val = 8'hFF;
		run_op(q, 3'h7, 3'h7, 1'b0, 1'b0);
		for (int w = 0; w < 8; w++) begin
			for (int d = 0; d < 4; d++) run_op(rnd_req(), 3'(w), 3'(d), 1'b0, 1'b0);
		end
		for (int i = 0; i < 150; i++) begin
			stall_mode <= 2'(nxt() % 4);
			run_op(rnd_req(), 3'(nxt() % 8), 3'(nxt() % 3), 1'b0, 1'b0);
		end
		@(posedge ref_clk);
		start <= 1'b1;
		req_in <= rnd_req();
		bus_wait_config <= 3'h7;
		@(posedge ref_clk);
		start <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk({ready, busy, done, instr_len, instr_cycles, result}, {3'b100, LEN_ONE, MC_ONE, RES_RST});
		run_op(rnd_req(), 3'h0, 3'h0, 1'b0, 1'b0);
		finish_test();
	end
endmodule
